// [rflt_chk.sv]
// Port checker for the fastlock timeout block.
// Assumes it is bound onto the block.
module rflt_chk (
	input wire logic SYS_CLK_I,
	input wire logic RESET_I,
	input wire logic RF_PD_EVENT_I,
	input wire logic NEW_FREQ_WORD_I,
	input wire logic EXTENDED_MODE_I,
	input wire logic [11:0] RF_FRAC_DEN_LOW_I,
	input wire logic [4:0] RF_STEADY_PUMP_MULT_I,
	input wire logic [21:0] RF_FRAC_DENOMINATOR_O,
	input wire logic [4:0] RF_PUMP_MULT_O,
	input wire logic FASTLOCK_ACTIVE_O,
	input wire logic RF_PD_SAMPLE_EN_O,
	input wire logic RF_LD_EVENT_O,
	input wire logic [1:0] CYCLE_SLIP_REDUCTION_O,
	input wire logic LOCK_DETECT_QUARTER_RATE_O,
	input wire logic RF_FASTLOCK_PIN_OE_O
);
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (RESET_I);
	a_den_std: assert property (!EXTENDED_MODE_I |=>
		RF_FRAC_DENOMINATOR_O == {10'h000, $past(RF_FRAC_DEN_LOW_I)}) else $error("den");
	a_pump_steady: assert property (!FASTLOCK_ACTIVE_O [*2] |->
		RF_PUMP_MULT_O == $past(RF_STEADY_PUMP_MULT_I)) else $error("pump");
	a_csr_idle: assert property (!FASTLOCK_ACTIVE_O |->
		CYCLE_SLIP_REDUCTION_O == 2'h0) else $error("csr");
	a_pin_drive: assert property (FASTLOCK_ACTIVE_O |-> RF_FASTLOCK_PIN_OE_O)
		else $error("oe");
	a_smp_cause: assert property (RF_PD_SAMPLE_EN_O |-> $past(RF_PD_EVENT_I))
		else $error("smp");
	a_ld_cause: assert property (RF_LD_EVENT_O |-> $past(RF_PD_EVENT_I))
		else $error("ld");
	a_ld_gap: assert property (RF_LD_EVENT_O && LOCK_DETECT_QUARTER_RATE_O |=>
		!RF_LD_EVENT_O [*3]) else $error("ld gap");
	a_smp_idle: assert property (RF_PD_EVENT_I && !NEW_FREQ_WORD_I && !FASTLOCK_ACTIVE_O
		##1 !FASTLOCK_ACTIVE_O |-> RF_PD_SAMPLE_EN_O) else $error("smp idle");
endmodule : rflt_chk

bind rflt_fastlock_timeout rflt_chk u_chk (.*);

// [rflt_fastlock_timeout.sv]
// Serial word capture, fastlock timeout counter, pin control and rate dividers.
// Assumes a three-line serial host whose clock stands still while the latch line is high,
// and comparison events and new-frequency strobes arriving on SYS_CLK_I.
//
// Overview of operation
// - Extended mode: denominator is upper ten plus lower twelve bits; else lower twelve.
// - Mode-select input widens the fractional denominator from twelve to twenty-two bits.
// - Fastlock word: cycle-slip top two, current code four, timeout fourteen, select low.
// - Lock-detect word recognised by all four select bits high; host zeros unused bits.
// - Timeout codes zero to three disable automatic fastlock; pin is general purpose.
// - Timeout codes four and up enable automatic fastlock; pin shows fastlock.
// - Automatic fastlock lasts twice the timeout value in comparison events.
// - Pin: code zero high impedance, code two low, code three high.
// - Code one forces fastlock continuously without timeout and drives the pin low.
// - During fastlock the pump multiple is the current code plus one.
// - During fastlock the cycle-slip code sets sample rate: off, half, quarter, sixteenth.
// - Quarter-rate bit divides comparison events to the lock detector by four.
`include "rflt_params.svh"

module rflt_fastlock_timeout #(
	parameter int TOC_WIDTH = 14,
	parameter int CPF_WIDTH = 4
)(
	input wire logic SYS_CLK_I,
	input wire logic RESET_I,
	input wire logic RF_SER_CLK_I,
	input wire logic RF_SER_DATA_I,
	input wire logic RF_SER_LATCH_I,
	input wire logic RF_PD_EVENT_I,
	input wire logic NEW_FREQ_WORD_I,
	input wire logic EXTENDED_MODE_I,
	input wire logic [11:0] RF_FRAC_DEN_LOW_I,
	input wire logic [4:0] RF_STEADY_PUMP_MULT_I,
	output logic [21:0] RF_FRAC_DENOMINATOR_O,
	output logic [4:0] RF_PUMP_MULT_O,
	output logic FASTLOCK_ACTIVE_O,
	output logic RF_PD_SAMPLE_EN_O,
	output logic RF_LD_EVENT_O,
	output logic [1:0] CYCLE_SLIP_REDUCTION_O,
	output logic LOCK_DETECT_QUARTER_RATE_O,
	output logic RF_FASTLOCK_PIN_O,
	output logic RF_FASTLOCK_PIN_OE_O
);

	// Field widths are tied to the fixed word layout
	if (TOC_WIDTH != 14 || CPF_WIDTH != 4)
	begin : g_width_check
		$error("rflt_fastlock_timeout: field widths are fixed by the word layout");
	end

	// Link domain: shift register only, never reset; its content is read only while
	// the latch line is high and the serial clock is still.
	logic [`RFLT_WORD_WIDTH-1:0] shift_q;

	always_ff @(posedge RF_SER_CLK_I)
	begin
		if (!RF_SER_LATCH_I)
			shift_q <= {shift_q[`RFLT_WORD_WIDTH-2:0], RF_SER_DATA_I};
	end

	// Latch line crossing; word is taken on the synchronised rising edge.
	logic latch_meta_q;
	logic latch_sync_q;
	logic latch_prev_q;
	logic word_take;

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RESET_I)
		begin
			latch_meta_q <= 1'b0;
			latch_sync_q <= 1'b0;
			latch_prev_q <= 1'b0;
		end
		else
		begin
			latch_meta_q <= RF_SER_LATCH_I;
			latch_sync_q <= latch_meta_q;
			latch_prev_q <= latch_sync_q;
		end
	end

	assign word_take = latch_sync_q & ~latch_prev_q;

	logic [3:0] word_sel;
	assign word_sel = shift_q[`RFLT_SEL_MSB:`RFLT_SEL_LSB];

	// Commit strobe for one register; unknown select codes never match
	function automatic logic word_hits(input logic take, input logic [3:0] sel,
		input logic [3:0] code);
		return take && (sel == code);
	endfunction : word_hits

	// Configuration fields
	logic [13:0] toc_q;
	logic [3:0] cpf_q;
	logic [1:0] csr_q;
	logic quarter_q;
	logic [9:0] den_high_q;

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RESET_I)
			toc_q <= `RFLT_TOC_RESET;
		else if (word_hits(word_take, word_sel, `RFLT_SEL_FASTLOCK))
			toc_q <= shift_q[`RFLT_TOC_MSB:`RFLT_TOC_LSB];
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RESET_I)
			cpf_q <= `RFLT_CPF_RESET;
		else if (word_hits(word_take, word_sel, `RFLT_SEL_FASTLOCK))
			cpf_q <= shift_q[`RFLT_CPF_MSB:`RFLT_CPF_LSB];
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RESET_I)
			csr_q <= `RFLT_CSR_RESET;
		else if (word_hits(word_take, word_sel, `RFLT_SEL_FASTLOCK))
			csr_q <= shift_q[`RFLT_CSR_MSB:`RFLT_CSR_LSB];
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RESET_I)
			quarter_q <= `RFLT_QUARTER_RESET;
		else if (word_hits(word_take, word_sel, `RFLT_SEL_LOCK_TEST))
			quarter_q <= shift_q[`RFLT_QUARTER_BIT];
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RESET_I)
			den_high_q <= `RFLT_DEN_HIGH_RESET;
		else if (word_hits(word_take, word_sel, `RFLT_SEL_FRAC_HIGH))
			den_high_q <= shift_q[`RFLT_DEN_HIGH_MSB:`RFLT_DEN_HIGH_LSB];
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RESET_I)
			RF_FRAC_DENOMINATOR_O <= `RFLT_DEN_RESET;
		else if (EXTENDED_MODE_I)
			RF_FRAC_DENOMINATOR_O <= {den_high_q, RF_FRAC_DEN_LOW_I};
		else
			RF_FRAC_DENOMINATOR_O <= {10'h000, RF_FRAC_DEN_LOW_I};
	end

	// Pin mode from the timeout code
	rflt_pkg::rflt_pin_mode_type pin_mode;
	logic auto_en;

	always_comb
	begin
		auto_en = (toc_q >= `RFLT_TOC_AUTO_MIN);
		unique case (toc_q)
			`RFLT_TOC_CODE_HIZ: pin_mode = rflt_pkg::PIN_HIZ;
			`RFLT_TOC_CODE_MANUAL: pin_mode = rflt_pkg::PIN_MANUAL_LOW;
			`RFLT_TOC_CODE_LOW: pin_mode = rflt_pkg::PIN_LOW;
			`RFLT_TOC_CODE_HIGH: pin_mode = rflt_pkg::PIN_HIGH;
			default: pin_mode = rflt_pkg::PIN_FASTLOCK;
		endcase
	end

	// Timeout counter, wide enough for twice the largest code
	logic [14:0] count_q;

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RESET_I)
			count_q <= 15'h0000;
		else if (!auto_en)
			count_q <= 15'h0000;
		else if (NEW_FREQ_WORD_I)
			count_q <= {toc_q, 1'b0};
		else if (RF_PD_EVENT_I && count_q != 15'h0000)
			count_q <= count_q - 15'h0001;
	end

	logic fastlock;
	// A new word wins over the final decrement, so fastlock never blinks off between words.
	// A lowered code must not let a stale count show fastlock for one cycle
	assign fastlock = (pin_mode == rflt_pkg::PIN_MANUAL_LOW)
		|| (auto_en && count_q != 15'h0000);

	// Cycle-slip sample gating, active only in fastlock
	logic [3:0] csr_cnt_q;
	logic [3:0] csr_mask;

	always_comb
	begin
		unique case (csr_q)
			2'h0: csr_mask = 4'h0;
			2'h1: csr_mask = `RFLT_CSR_HALF_MASK;
			2'h2: csr_mask = `RFLT_CSR_QUARTER_MASK;
			2'h3: csr_mask = `RFLT_CSR_SIXTEENTH_MASK;
		endcase
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RESET_I || !fastlock)
			csr_cnt_q <= 4'h0;
		else if (RF_PD_EVENT_I)
			csr_cnt_q <= (csr_cnt_q + 4'h1) & csr_mask;
	end

	// Lock-detect divider
	logic [1:0] ld_cnt_q;

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RESET_I || !quarter_q)
			ld_cnt_q <= 2'h0;
		else if (RF_PD_EVENT_I)
			ld_cnt_q <= ld_cnt_q + 2'h1;
	end

	// Registered outputs
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RESET_I)
			RF_PD_SAMPLE_EN_O <= 1'b0;
		else
			RF_PD_SAMPLE_EN_O <= RF_PD_EVENT_I && (!fastlock || csr_cnt_q == 4'h0);
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RESET_I)
			RF_LD_EVENT_O <= 1'b0;
		else
			RF_LD_EVENT_O <= RF_PD_EVENT_I && (!quarter_q || ld_cnt_q == `RFLT_LD_DIVIDE);
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RESET_I)
			FASTLOCK_ACTIVE_O <= 1'b0;
		else
			FASTLOCK_ACTIVE_O <= fastlock;
	end

	// Steady multiple is not latched, so a change to it shows one cycle later outside fastlock
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RESET_I)
			RF_PUMP_MULT_O <= `RFLT_PUMP_MULT_RESET;
		else if (fastlock)
			RF_PUMP_MULT_O <= {1'b0, cpf_q} + 5'h01;
		else
			RF_PUMP_MULT_O <= RF_STEADY_PUMP_MULT_I;
	end

	// Expiry disables cycle-slip reduction along with the current boost
	always_ff @(posedge SYS_CLK_I)
	begin
		if (RESET_I)
			CYCLE_SLIP_REDUCTION_O <= 2'h0;
		else if (fastlock)
			CYCLE_SLIP_REDUCTION_O <= csr_q;
		else
			CYCLE_SLIP_REDUCTION_O <= 2'h0;
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RESET_I)
			LOCK_DETECT_QUARTER_RATE_O <= 1'b0;
		else
			LOCK_DETECT_QUARTER_RATE_O <= quarter_q;
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (RESET_I)
		begin
			RF_FASTLOCK_PIN_O <= 1'b0;
			RF_FASTLOCK_PIN_OE_O <= 1'b0;
		end
		else
		begin
			unique case (pin_mode)
				rflt_pkg::PIN_HIZ:
				begin
					RF_FASTLOCK_PIN_O <= 1'b0;
					RF_FASTLOCK_PIN_OE_O <= 1'b0;
				end
				rflt_pkg::PIN_MANUAL_LOW, rflt_pkg::PIN_LOW:
				begin
					RF_FASTLOCK_PIN_O <= 1'b0;
					RF_FASTLOCK_PIN_OE_O <= 1'b1;
				end
				rflt_pkg::PIN_HIGH:
				begin
					RF_FASTLOCK_PIN_O <= 1'b1;
					RF_FASTLOCK_PIN_OE_O <= 1'b1;
				end
				rflt_pkg::PIN_FASTLOCK:
				begin
					RF_FASTLOCK_PIN_O <= fastlock;
					RF_FASTLOCK_PIN_OE_O <= 1'b1;
				end
			endcase
		end
	end

endmodule : rflt_fastlock_timeout

// [rflt_fastlock_timeout_bench.sv]
// Bench with a serial host and directed checks of the block's outputs.
// Assumes rflt_host and rflt_chk are compiled first.
module rflt_fastlock_timeout_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, lck = 0, ev = 0, nf = 0, ext = 0;
	logic sck, sda, lat, act, smp, ld, qr, pin, oe;
	logic [11:0] dlo = 12'h000;
	logic [4:0] stp = 5'h00, pm;
	logic [21:0] den;
	logic [1:0] cycle_slip_reduction;
	logic [31:0] sd = 32'h16ddb02b;
	int err_count = 0, checks_done = 0, cyc = 0, nsm = 0, nld = 0;
	initial forever #20 clk = ~clk;
	initial #7 forever #40 lck = ~lck;
	always @(negedge clk)
	begin
		nsm += smp;
		nld += ld;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			err_count++;
			complete_run();
		end
	end
	rflt_host u_host (.lck_i(lck), .sck_o(sck), .sda_o(sda), .lat_o(lat));
	rflt_fastlock_timeout u_dut (.SYS_CLK_I(clk), .RESET_I(rst), .RF_SER_CLK_I(sck),
		.RF_SER_DATA_I(sda), .RF_SER_LATCH_I(lat), .RF_PD_EVENT_I(ev), .NEW_FREQ_WORD_I(nf),
		.EXTENDED_MODE_I(ext), .RF_FRAC_DEN_LOW_I(dlo), .RF_STEADY_PUMP_MULT_I(stp),
		.RF_FRAC_DENOMINATOR_O(den), .RF_PUMP_MULT_O(pm), .FASTLOCK_ACTIVE_O(act),
		.RF_PD_SAMPLE_EN_O(smp), .RF_LD_EVENT_O(ld), .CYCLE_SLIP_REDUCTION_O(cycle_slip_reduction),
		.LOCK_DETECT_QUARTER_RATE_O(qr), .RF_FASTLOCK_PIN_O(pin), .RF_FASTLOCK_PIN_OE_O(oe));
	function automatic logic [31:0] rnd();
		sd ^= sd << 13;
		sd ^= sd >> 17;
		sd ^= sd << 5;
		return sd;
	endfunction : rnd
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Events every other cycle; ends settled one cycle after the last
	task automatic evs(input int n);
		repeat (n)
		begin
			@(posedge clk) ev <= 1;
			@(posedge clk) ev <= 0;
		end
		@(posedge clk);
		@(negedge clk);
	endtask : evs
	task automatic newf();
		@(posedge clk) nf <= 1;
		@(posedge clk) nf <= 0;
		@(posedge clk);
		@(negedge clk);
	endtask : newf
	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run
	initial
	begin
		int c, t;
		repeat (10) @(posedge clk);
		rst <= 0;
		dlo <= 12'(rnd());
		stp <= 5'(rnd());
		@(negedge clk);
		chk({oe, pm}, 6'h01);
		for (int k = 0; k < 4; k++)
		begin
			c = rnd() & 15;
			u_host.send({2'(k), 4'(c), 14'(k), 4'hd});
			newf();
			chk({oe, oe & pin, act, cycle_slip_reduction}, {k != 0, k == 3, k == 1, 2'(k == 1)});
			chk(pm, k == 1 ? c + 1 : stp);
		end
		for (int s = 0; s < 4; s++)
		begin
			c = rnd() & 15;
			u_host.send({2'(s), 4'(c), 14'd8, 4'hd});
			newf();
			nsm = 0;
			nld = 0;
			chk({oe & pin & act, cycle_slip_reduction, pm}, {1'b1, 2'(s), 5'(c + 1)});
			evs(15);
			chk(act, 1);
			evs(1);
			chk({act, pin, cycle_slip_reduction, pm}, {4'h0, stp});
			chk(nsm, 16 >> (s == 3 ? 4 : s));
			chk(nld, 16);
		end
		t = 4 + (rnd() & 7);
		u_host.send({6'h00, 14'(t), 4'hd});
		newf();
		evs(3);
		newf();
		evs(2 * t - 1);
		chk(act, 1);
		evs(1);
		chk(act, 0);
		u_host.send(24'h00400f);
		u_host.send(24'h00000c);
		nsm = 0;
		nld = 0;
		evs(8);
		chk(qr, 1);
		chk(nld, 2);
		chk(nsm, 8);
		u_host.send(24'h00000f);
		chk(qr, 0);
		t = rnd();
		u_host.send({10'(t), 10'h000, 4'hb});
		for (int x = 1; x >= 0; x--)
		begin
			@(posedge clk) ext <= 1'(x);
			@(posedge clk);
			@(negedge clk);
			chk(den, x ? {10'(t), dlo} : 22'(dlo));
		end
		complete_run();
	end
endmodule : rflt_fastlock_timeout_bench

// [rflt_host.sv]
// Host model shifting 24-bit words MSB first, then raising the latch.
// Assumes a free link clock; gated so it stands still between frames.
module rflt_host (
	input wire logic lck_i,
	output logic sck_o,
	output logic sda_o = 1'b0,
	output logic lat_o = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic en = 1'b0;
	assign sck_o = lck_i & en;
	task automatic send(input logic [23:0] w);
		for (int i = 23; i >= 0; i--)
		begin
			@(negedge lck_i);
			en = 1;
			sda_o = w[i];
		end
		@(negedge lck_i);
		en = 0;
		// Released line flips, so no stale bit passes
		sda_o = ~sda_o;
		lat_o = 1;
		repeat (3) @(negedge lck_i);
		lat_o = 0;
	endtask : send
endmodule : rflt_host

// [rflt_params.svh]
// Constants for the fastlock timeout control block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef RFLT_PARAMS_SVH
`define RFLT_PARAMS_SVH

`define RFLT_WORD_WIDTH 24
`define RFLT_SEL_LSB 0
`define RFLT_SEL_MSB 3
`define RFLT_SEL_FASTLOCK 4'hd
`define RFLT_SEL_LOCK_TEST 4'hf
`define RFLT_SEL_FRAC_HIGH 4'hb
`define RFLT_TOC_LSB 4
`define RFLT_TOC_MSB 17
`define RFLT_CPF_LSB 18
`define RFLT_CPF_MSB 21
`define RFLT_CSR_LSB 22
`define RFLT_CSR_MSB 23
`define RFLT_DEN_HIGH_LSB 14
`define RFLT_DEN_HIGH_MSB 23
`define RFLT_QUARTER_BIT 14
`define RFLT_TOC_RESET 14'h0000
`define RFLT_CPF_RESET 4'h0
`define RFLT_CSR_RESET 2'h0
`define RFLT_QUARTER_RESET 1'b0
`define RFLT_DEN_HIGH_RESET 10'h000
`define RFLT_DEN_RESET 22'h000000
`define RFLT_PUMP_MULT_RESET 5'h01
`define RFLT_TOC_AUTO_MIN 14'h0004
`define RFLT_TOC_CODE_HIZ 14'h0000
`define RFLT_TOC_CODE_MANUAL 14'h0001
`define RFLT_TOC_CODE_LOW 14'h0002
`define RFLT_TOC_CODE_HIGH 14'h0003
`define RFLT_LD_DIVIDE 2'h3
`define RFLT_CSR_HALF_MASK 4'h1
`define RFLT_CSR_QUARTER_MASK 4'h3
`define RFLT_CSR_SIXTEENTH_MASK 4'hf

`endif

// [rflt_pkg.sv]
// Types for the fastlock timeout control block.
// Assumes rflt_params.svh is on the include path.
`include "rflt_params.svh"

package rflt_pkg;
	typedef enum logic [2:0]
	{
		PIN_HIZ,
		PIN_MANUAL_LOW,
		PIN_LOW,
		PIN_HIGH,
		PIN_FASTLOCK
	} rflt_pin_mode_type;

	typedef enum logic [1:0]
	{
		CSR_OFF,
		CSR_HALF,
		CSR_QUARTER,
		CSR_SIXTEENTH
	} rflt_csr_type;
endpackage : rflt_pkg
